// ### logic/eac_pkg.sv
/*
 eeprom access control package: control register layout, register
 selects, reset values and programming times.
 assumes a 40 MHz system clock shared with the core register port.
*/
package eac_pkg;
  localparam int          CLK_HZ          = 40_000_000;
  localparam logic [1:0]  SEL_CTRL        = 2'h0;
  localparam logic [1:0]  SEL_ADDR_LO     = 2'h1;
  localparam logic [1:0]  SEL_ADDR_HI     = 2'h2;
  localparam logic [1:0]  SEL_DATA        = 2'h3;
  localparam int          BIT_READ        = 0;
  localparam int          BIT_PROG        = 1;
  localparam int          BIT_MASTER      = 2;
  localparam int          BIT_RDY_IE      = 3;
  localparam int          BIT_MODE_LO     = 4;
  localparam int          BIT_MODE_HI     = 5;
  localparam logic [1:0]  MODE_RESET      = 2'h0;
  localparam logic [7:0]  DATA_RESET      = 8'h00;
  localparam logic [2:0]  MASTER_CYCLES   = 3'h4;
  localparam logic [2:0]  READ_STALL      = 3'h4;
  localparam logic [2:0]  PROG_STALL      = 3'h2;
  localparam int          ATOMIC_US10     = 34;
  localparam int          SPLIT_US10      = 18;
  localparam int          ATOMIC_CYC      = ATOMIC_US10 * (CLK_HZ / 10_000);
  localparam int          SPLIT_CYC       = SPLIT_US10 * (CLK_HZ / 10_000);
  typedef enum logic [1:0] {
    EAC_ATOMIC, EAC_ERASE, EAC_WRITE, EAC_RSVD
  } eac_mode_t;
endpackage

// ### logic/eac_eeprom_ctrl.sv
/*
 eeprom access control: core register port on one side, byte array
 port on the other. the array answers reads combinationally in the cycle
 the read is requested, one cycle before arr_rd. assumes all inputs come from the same clock domain.
 assumes the core issues no register write while core_stall is high, and
 that srst may arrive mid-programming: the array cycle is never cut short.
*/
`timescale 1ns/1ps
module eac_eeprom_ctrl import eac_pkg::*; #(
  parameter int ATOMIC_TIME = ATOMIC_CYC,
  parameter int SPLIT_TIME  = SPLIT_CYC
) (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       reg_wr,
  input  wire logic [1:0] reg_sel,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] ctrl_rdata,
  output logic      [8:0] nv_byte_address,
  output logic      [7:0] nv_byte_data,
  input  wire logic       global_irq_en,
  output logic            ready_irq,
  output logic            core_stall,
  output logic            arr_rd,
  input  wire logic [7:0] arr_rdata,
  output logic            arr_erase,
  output logic            arr_write,
  output logic      [7:0] arr_wdata
);
  logic [1:0]  prog_mode_r;
  logic        ready_irq_enable_r;
  logic        master_prog_enable_r;
  logic        prog_enable_r;
  logic [2:0]  master_cnt_r;
  logic [2:0]  stall_cnt_r;
  logic [23:0] prog_cnt_r;
  logic        wr_ctrl;
  logic        start;
  logic        rd_go;

  assign wr_ctrl = reg_wr && (reg_sel == SEL_CTRL);
  // start needs master enable still live; none may begin inside reset
  assign start = wr_ctrl && reg_wdata[BIT_PROG] && master_prog_enable_r
                 && !prog_enable_r && !srst;
  assign rd_go = wr_ctrl && reg_wdata[BIT_READ] && !prog_enable_r;

  always_ff @(posedge clk) begin
    if (srst && !prog_enable_r) begin
      prog_mode_r <= MODE_RESET;
    end else if (wr_ctrl && !prog_enable_r) begin
      prog_mode_r <= reg_wdata[BIT_MODE_HI:BIT_MODE_LO];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ready_irq_enable_r <= 1'b0;
    end else if (wr_ctrl) begin
      ready_irq_enable_r <= reg_wdata[BIT_RDY_IE];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      master_prog_enable_r <= 1'b0;
      master_cnt_r         <= 3'h0;
    end else if (wr_ctrl && reg_wdata[BIT_MASTER]) begin
      master_prog_enable_r <= 1'b1;
      master_cnt_r         <= MASTER_CYCLES - 3'h1;
    end else if (master_cnt_r != 3'h0) begin
      master_cnt_r <= master_cnt_r - 3'h1;
    end else begin
      master_prog_enable_r <= 1'b0;
    end
  end

  // a running program finishes across reset, so reset clears these only when idle
  always_ff @(posedge clk) begin
    if (start) begin
      prog_enable_r <= 1'b1;
      prog_cnt_r    <= (prog_mode_r == MODE_RESET) ?
                       24'(ATOMIC_TIME - 1) : 24'(SPLIT_TIME - 1);
    end else if (prog_enable_r && prog_cnt_r != 24'h0) begin
      prog_cnt_r <= prog_cnt_r - 24'h1;
    end else if (srst || prog_enable_r) begin
      prog_enable_r <= 1'b0;
      prog_cnt_r    <= 24'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      stall_cnt_r <= 3'h0;
      core_stall  <= 1'b0;
    end else if (start) begin
      stall_cnt_r <= PROG_STALL - 3'h1;
      core_stall  <= 1'b1;
    end else if (rd_go) begin
      stall_cnt_r <= READ_STALL - 3'h1;
      core_stall  <= 1'b1;
    end else if (stall_cnt_r != 3'h0) begin
      stall_cnt_r <= stall_cnt_r - 3'h1;
    end else begin
      core_stall <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reg_wr && !prog_enable_r && reg_sel == SEL_ADDR_LO) begin
      nv_byte_address[7:0] <= reg_wdata;
    end else if (reg_wr && !prog_enable_r && reg_sel == SEL_ADDR_HI) begin
      nv_byte_address[8] <= reg_wdata[0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      nv_byte_data <= DATA_RESET;
    end else if (rd_go) begin
      nv_byte_data <= arr_rdata;
    end else if (reg_wr && reg_sel == SEL_DATA) begin
      nv_byte_data <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      arr_erase <= 1'b0;
      arr_write <= 1'b0;
      arr_wdata <= DATA_RESET;
      arr_rd    <= 1'b0;
    end else begin
      arr_erase <= start && (prog_mode_r == EAC_ATOMIC ||
                             prog_mode_r == EAC_ERASE);
      arr_write <= start && (prog_mode_r == EAC_ATOMIC ||
                             prog_mode_r == EAC_WRITE);
      arr_wdata <= nv_byte_data;
      arr_rd    <= rd_go;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ready_irq <= 1'b0;
    end else begin
      ready_irq <= ready_irq_enable_r && global_irq_en &&
                   !(prog_enable_r || start);
    end
  end

  always_ff @(posedge clk) begin
    ctrl_rdata <= {2'b00, prog_mode_r, ready_irq_enable_r,
                   master_prog_enable_r, prog_enable_r, 1'b0};
  end

  // checker-only measures: how long the busy flag really stood and how
  // long it should stand, taken from the parameters rather than from the
  // countdown, so a wrong load value in that countdown still shows up
  logic [23:0] busy_len_r;
  logic [23:0] busy_lim_r;
  logic [2:0]  stall_len_r;

  always_ff @(posedge clk) begin
    if (start) begin
      busy_len_r <= 24'h0;
    end else if (prog_enable_r) begin
      busy_len_r <= busy_len_r + 24'h1;
    end else begin
      busy_len_r <= 24'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (start && prog_mode_r == EAC_ATOMIC) begin
      busy_lim_r <= 24'(ATOMIC_TIME);
    end else if (start) begin
      busy_lim_r <= 24'(SPLIT_TIME);
    end
  end

  // saturates so a stuck stall cannot wrap back into the legal range
  always_ff @(posedge clk) begin
    if (srst || !core_stall) begin
      stall_len_r <= 3'h0;
    end else if (stall_len_r != 3'h7) begin
      stall_len_r <= stall_len_r + 3'h1;
    end
  end

  // master enable window and programming start
  a_mpe_hold: assert property (@(posedge clk) disable iff (srst)
    wr_ctrl && reg_wdata[BIT_MASTER] |=> master_prog_enable_r [*4])
    else $error("master enable window short");

  a_mpe_clear: assert property (@(posedge clk) disable iff (srst)
    (wr_ctrl && reg_wdata[BIT_MASTER])
      ##1 !(wr_ctrl && reg_wdata[BIT_MASTER]) [*4]
      |=> !master_prog_enable_r)
    else $error("master enable stuck");

  a_no_start: assert property (@(posedge clk) disable iff (srst)
    !master_prog_enable_r |=> !arr_write && !arr_erase)
    else $error("write without master");

  a_no_arm: assert property (@(posedge clk) disable iff (srst)
    !master_prog_enable_r && !prog_enable_r |=> !prog_enable_r)
    else $error("program started without master");

  a_busy_set: assert property (@(posedge clk) disable iff (srst)
    start |=> prog_enable_r)
    else $error("program flag not set");

  a_busy_max: assert property (@(posedge clk) disable iff (srst)
    prog_enable_r |-> busy_len_r < busy_lim_r)
    else $error("program flag held too long");

  a_busy_len: assert property (@(posedge clk) disable iff (srst)
    $fell(prog_enable_r) |-> busy_len_r == busy_lim_r)
    else $error("program flag cleared early");

  // array action per mode; the reserved code must leave the array alone
  a_atomic_ops: assert property (@(posedge clk) disable iff (srst)
    start && prog_mode_r == EAC_ATOMIC |=> arr_erase && arr_write)
    else $error("atomic mode pulses wrong");

  a_erase_only: assert property (@(posedge clk) disable iff (srst)
    start && prog_mode_r == EAC_ERASE |=> arr_erase && !arr_write)
    else $error("erase mode pulses wrong");

  a_write_only: assert property (@(posedge clk) disable iff (srst)
    start && prog_mode_r == EAC_WRITE |=> !arr_erase && arr_write)
    else $error("write mode pulses wrong");

  a_rsvd_idle: assert property (@(posedge clk) disable iff (srst)
    start && prog_mode_r == EAC_RSVD |=> !arr_erase && !arr_write)
    else $error("reserved mode touched array");

  a_mode_hold: assert property (@(posedge clk) disable iff (srst)
    prog_enable_r |=> $stable(prog_mode_r))
    else $error("mode changed while busy");

  // core stall lengths
  a_prog_stall: assert property (@(posedge clk) disable iff (srst)
    start |=> core_stall [*2] ##1 !core_stall)
    else $error("program stall length");

  a_read_stall: assert property (@(posedge clk) disable iff (srst)
    rd_go |=> core_stall [*4] ##1 !core_stall)
    else $error("read stall length");

  a_stall_max: assert property (@(posedge clk) disable iff (srst)
    !(stall_len_r > READ_STALL))
    else $error("core stalled too long");

  // read path and its refusal while busy
  a_read_data: assert property (@(posedge clk) disable iff (srst)
    rd_go |=> nv_byte_data == $past(arr_rdata))
    else $error("read data lost");

  a_read_pulse: assert property (@(posedge clk) disable iff (srst)
    rd_go |=> arr_rd)
    else $error("read strobe missing");

  a_busy_no_read: assert property (@(posedge clk) disable iff (srst)
    prog_enable_r |=> !arr_rd)
    else $error("read while busy");

  a_busy_addr: assert property (@(posedge clk) disable iff (srst)
    prog_enable_r |=> $stable(nv_byte_address))
    else $error("address changed while busy");

  // ready interrupt level
  a_irq_level: assert property (@(posedge clk) disable iff (srst)
    prog_enable_r |=> !ready_irq)
    else $error("irq while busy");

  a_irq_ready: assert property (@(posedge clk) disable iff (srst)
    ready_irq_enable_r && global_irq_en && !prog_enable_r && !start
      |=> ready_irq)
    else $error("ready irq missing");

  a_irq_gate: assert property (@(posedge clk) disable iff (srst)
    !global_irq_en |=> !ready_irq)
    else $error("irq not gated");

  a_irq_enable: assert property (@(posedge clk) disable iff (srst)
    !ready_irq_enable_r |=> !ready_irq)
    else $error("irq not disabled");

  // reset: the mode survives only while the array is still busy
  a_mode_reset: assert property (@(posedge clk)
    srst && !prog_enable_r |=> prog_mode_r == MODE_RESET)
    else $error("mode not cleared by reset");

  a_mode_busy_rst: assert property (@(posedge clk)
    srst && prog_enable_r |=> $stable(prog_mode_r))
    else $error("mode lost during busy reset");

  a_data_write: assert property (@(posedge clk) disable iff (srst)
    reg_wr && reg_sel == SEL_DATA |=> nv_byte_data == $past(reg_wdata))
    else $error("data register write lost");

  a_addr_write: assert property (@(posedge clk) disable iff (srst)
    reg_wr && reg_sel == SEL_ADDR_LO && !prog_enable_r
      |=> nv_byte_address[7:0] == $past(reg_wdata))
    else $error("address write lost");

  a_top_zero: assert property (@(posedge clk) disable iff (srst)
    ctrl_rdata[7:6] == 2'b00)
    else $error("reserved bits set");
endmodule // eac_eeprom_ctrl

// ### verification/eac_array_model.sv
/*
 byte array model behind the eeprom access control block.
 assumes the controller's registered erase/write pulses on clk.
*/
`timescale 1ns/1ps
module eac_array_model import eac_pkg::*; (
  input  wire logic       clk,
  input  wire logic [8:0] nv_byte_address,
  input  wire logic       arr_erase,
  input  wire logic       arr_write,
  input  wire logic [7:0] arr_wdata,
  output logic      [7:0] arr_rdata
);
  logic [7:0] mem_r [512];
  initial foreach (mem_r[i]) mem_r[i] = 8'hff;
  assign arr_rdata = mem_r[nv_byte_address];
  // write alone only clears bits, as a real cell does without erase
  always @(posedge clk) begin
    if (arr_erase || arr_write) begin
      mem_r[nv_byte_address] <= (arr_erase ? 8'hff : mem_r[nv_byte_address])
                                & (arr_write ? arr_wdata : 8'hff);
    end
  end
endmodule // eac_array_model

// ### verification/eac_eeprom_ctrl_tb_top.sv
/*
 self-checking bench for the eeprom access control block.
 assumes the array model answers reads combinationally.
*/
`timescale 1ns/1ps
module eac_eeprom_ctrl_tb_top import eac_pkg::*;;
  typedef struct {logic [1:0] m; logic [7:0] d, rd; int er, wr, t;} eac_row_t;
  logic clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, global_irq_en = 1'b1;
  logic [1:0] reg_sel = 2'h0;
  logic [7:0] reg_wdata = 8'h00, ctrl_rdata, nv_byte_data, arr_rdata, arr_wdata;
  logic [8:0] nv_byte_address;
  logic       ready_irq, core_stall, arr_rd, arr_erase, arr_write;
  int n_mismatch = 0, checks_done = 0, n_er, n_wr, n_rd, st_n = 0, st_last;
  eac_row_t rows [4] = '{'{2'h0, 8'h3c, 8'h3c, 1, 1, 20},
    '{2'h1, 8'h00, 8'hff, 1, 0, 10}, '{2'h2, 8'h5a, 8'h5a, 0, 1, 10},
    '{2'h3, 8'h11, 8'h5a, 0, 0, 10}};
  eac_eeprom_ctrl #(.ATOMIC_TIME(20), .SPLIT_TIME(10)) i_eac_eeprom_ctrl (
    .clk, .srst, .reg_wr, .reg_sel, .reg_wdata, .ctrl_rdata, .nv_byte_address,
    .nv_byte_data, .global_irq_en, .ready_irq, .core_stall, .arr_rd,
    .arr_rdata, .arr_erase, .arr_write, .arr_wdata);
  eac_array_model i_eac_array_model (.clk, .nv_byte_address, .arr_erase,
    .arr_write, .arr_wdata, .arr_rdata);
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    n_er += arr_erase;
    n_wr += arr_write;
    n_rd += arr_rd;
    if (core_stall === 1'b1) st_n++;
    else if (st_n != 0) begin
      st_last = st_n;
      st_n = 0;
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_sel = s;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic start(input logic [1:0] m, input logic ie);
    wr(SEL_CTRL, {2'b00, m, ie, 3'b100});
    wr(SEL_CTRL, {2'b00, m, ie, 3'b110});
  endtask
  task automatic tally_and_finish;
    if (n_mismatch == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    cyc(3);
    srst = 1'b0;
    wr(SEL_ADDR_HI, 8'h01);
    wr(SEL_ADDR_LO, 8'ha5);
    foreach (rows[i]) begin
      wr(SEL_DATA, rows[i].d);
      {n_er, n_wr, n_rd} = '0;
      start(rows[i].m, 1'b1);
      cyc(1);
      chk("prog", 1, ctrl_rdata[1]);
      chk("irq_busy", 0, ready_irq);
      // busy: mode change, read and address change must all be dropped
      wr(SEL_CTRL, {2'b00, ~rows[i].m, 4'b1011});
      wr(SEL_ADDR_LO, 8'h00);
      cyc(1);
      chk("mode", 9'(rows[i].m), 9'(ctrl_rdata[5:4]));
      chk("addr", 9'h1a5, nv_byte_address);
      chk("pstall", 2, 9'(st_last));
      cyc(rows[i].t);
      chk("done", 0, ctrl_rdata[1]);
      chk("irq_rdy", 1, ready_irq);
      chk("erase", 9'(rows[i].er), 9'(n_er));
      chk("write", 9'(rows[i].wr), 9'(n_wr));
      wr(SEL_CTRL, {2'b00, rows[i].m, 4'b1001});
      cyc(6);
      chk("rdata", 9'(rows[i].rd), 9'(nv_byte_data));
      chk("rstall", 4, 9'(st_last));
      chk("nread", 1, 9'(n_rd));
    end
    wr(SEL_CTRL, 8'h04);
    cyc(1);
    chk("master", 1, ctrl_rdata[2]);
    cyc(5);
    chk("master_clr", 0, ctrl_rdata[2]);
    {n_er, n_wr} = '0;
    wr(SEL_CTRL, 8'h0a);
    cyc(3);
    chk("noprog", 0, ctrl_rdata[1]);
    chk("ie_rd", 1, ctrl_rdata[3]);
    chk("nopulse", 0, 9'(n_er + n_wr));
    chk("rsvd", 0, 9'(ctrl_rdata[7:6]));
    global_irq_en = 1'b0;
    cyc(2);
    chk("irq_gie", 0, ready_irq);
    global_irq_en = 1'b1;
    wr(SEL_CTRL, 8'h00);
    cyc(2);
    chk("irq_ie", 0, ready_irq);
    start(2'h1, 1'b0);
    srst = 1'b1;
    cyc(1);
    srst = 1'b0;
    cyc(2);
    chk("mode_busy", 1, 9'(ctrl_rdata[5:4]));
    chk("prog_rst", 1, ctrl_rdata[1]);
    cyc(12);
    srst = 1'b1;
    cyc(1);
    srst = 1'b0;
    cyc(2);
    chk("mode_rst", 0, 9'(ctrl_rdata[5:4]));
    chk("data_rst", 0, 9'(nv_byte_data));
    tally_and_finish();
  end
  initial begin
    repeat (2000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule // eac_eeprom_ctrl_tb_top
